// >>> bitplane_playfield.sv
`timescale 1ns/1ps
`default_nettype none
`include "playfield_consts.svh"

// Function
// - at line end each active plane pointer gains its modulo
// - odd planes use the odd modulo, even planes the even modulo
// - misc control bit 15 selects high resolution
// - bits 14..12 give active plane count, zero to six
// - bit 11 enables hold-and-modify colour
// - bit 10 enables dual playfield, odd planes one, even planes two
// - bit 9 composite video; bit 8 genlock audio on background pin in vblank
// - bits 3,2,1 light pen, interlace, external sync; cleared at reset
// - external sync turns sync pads into inputs
// - scroll register holds playfield two code 7..4, one code 3..0
// - priority bit 6 puts playfield two in front
// - priority bits 5..3 and 2..0 hold sprite priority codes
// - six plane data words, loaded by DMA or processor
// - writing plane one data starts sixteen-pixel serialization
// - each plane word shifts out most significant bit first
// - 18-bit plane pointer written as 3-bit high and 15-bit low parts
// - collision control bits 15..12 OR odd sprites into their pair
// - bits 11..6 enable planes, bits 5..0 give match values
// - disabled planes never block collisions
// - reading the collision result clears it
// - result bit layout: pf-pf, pf-sprite pairs, sprite-sprite; bit 15 unused
module bitplane_playfield import playfield_pkg::*; #(
  parameter int NPLANES = 6
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [11:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // plane dma channel
  input wire logic fetch_i,
  input wire logic [2:0] fetch_plane_i,
  input wire logic [15:0] fetch_data_i,
  output logic [17:0] fetch_addr_o,
  // beam timing
  input wire logic line_end_i,
  input wire logic vblank_i,
  input wire logic hsync_gen_i,
  input wire logic vsync_gen_i,
  input wire logic [7:0] sprite_pix_i,
  input wire logic background_i,
  input wire logic genlock_audio_i,
  // sync pads
  input wire logic hsync_pad_i,
  input wire logic vsync_pad_i,
  output logic hsync_pad_o,
  output logic vsync_pad_o,
  output logic sync_pad_oe_o,
  output logic hsync_ext_o,
  output logic vsync_ext_o,
  // display outputs
  output logic background_output_pin_o,
  output pixel_t pixel_o,
  output disp_ctl_t disp_ctl_o
);

  typedef struct packed {
    logic aw_got;
    logic [9:0] aw_idx;
    logic w_got;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] plane_control_misc;
    logic [15:0] plane_scroll_control;
    logic [15:0] plane_priority_control;
    logic [15:0] odd_plane_modulo;
    logic [15:0] even_plane_modulo;
    logic [15:0] collision_control;
    logic [15:0] collision_result;
    logic [NPLANES-1:0][17:0] ptr;
    logic [NPLANES-1:0][15:0] dat;
    logic [NPLANES-1:0][15:0] shreg;
    ser_state_t ser;
    logic [4:0] bits_left;
    logic half;
    pixel_t pix;
    logic [17:0] fetch_addr;
    logic hs_meta;
    logic vs_meta;
    logic hs_sync;
    logic vs_sync;
    logic hs_out;
    logic vs_out;
    logic sync_oe;
    logic background_output_pin;
    disp_ctl_t disp;
  } state_t;

  state_t s;
  state_t n;
  logic [14:0] hits;
  logic load;
  logic step;
  logic [2:0] active;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [17:0] add_mod(input logic [17:0] p, input logic [15:0] m);
    // modulo is in bytes, pointer counts words
    add_mod = p + {{3{m[15]}}, m[15:1]};
  endfunction

  // disabled planes and planes of the other playfield never veto
  function automatic logic pf_match(input logic [5:0] pl, input logic [5:0] en, input logic [5:0] val,
                                    input logic odd_set);
    pf_match = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (((i % 2) == (odd_set ? 0 : 1)) && en[i] && (pl[i] != val[i])) begin
        pf_match = 1'b0;
      end
    end
  endfunction

  function automatic logic [2:0] clamp_count(input logic [2:0] c);
    clamp_count = (c > `MAX_PLANES) ? `MAX_PLANES : c;
  endfunction

  // ----------------------------------------
  // collision terms
  // ----------------------------------------
  logic pf1_hit;
  logic pf2_hit;
  logic [3:0] grp;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      grp[k] = sprite_pix_i[2*k] | (s.collision_control[`B_ODD_SPRITE_INCLUDE_LO + k] & sprite_pix_i[2*k+1]);
    end
    pf1_hit = pf_match(s.pix.planes, s.collision_control[`B_PLANE_MATCH_INCLUDE_HI:`B_PLANE_MATCH_INCLUDE_LO],
                       s.collision_control[`B_PLANE_MATCH_VALUE_HI:`B_PLANE_MATCH_VALUE_LO], 1'b1);
    pf2_hit = pf_match(s.pix.planes, s.collision_control[`B_PLANE_MATCH_INCLUDE_HI:`B_PLANE_MATCH_INCLUDE_LO],
                       s.collision_control[`B_PLANE_MATCH_VALUE_HI:`B_PLANE_MATCH_VALUE_LO], 1'b0);
    hits = '0;
    if (s.pix.valid) begin
      hits[0] = pf1_hit & pf2_hit;
      hits[4:1] = {4{pf1_hit}} & grp;
      hits[8:5] = {4{pf2_hit}} & grp;
      hits[9] = grp[0] & grp[1];
      hits[10] = grp[0] & grp[2];
      hits[11] = grp[0] & grp[3];
      hits[12] = grp[1] & grp[2];
      hits[13] = grp[1] & grp[3];
      hits[14] = grp[2] & grp[3];
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    load = 1'b0;
    active = clamp_count(s.plane_control_misc[`B_COUNT_HI:`B_COUNT_LO]);
    // axi address and data may arrive in either order
    if (s_axi_awvalid_i && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_idx = s_axi_awaddr_i[11:2];
    end
    if (s_axi_wvalid_i && s.wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata_i[15:0];
      n.w_strb = s_axi_wstrb_i[1:0];
    end
    if (s.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    // pointers: fetch advance, then line-end modulo
    if (fetch_i && (fetch_plane_i < 3'(NPLANES))) begin
      n.ptr[fetch_plane_i] = s.ptr[fetch_plane_i] + `PTR_STEP;
      n.dat[fetch_plane_i] = fetch_data_i;
      load = (fetch_plane_i == 3'h0);
    end
    if (line_end_i) begin
      for (int p = 0; p < NPLANES; p++) begin
        if (p < int'(active)) begin
          n.ptr[p] = add_mod(n.ptr[p], (p % 2 == 0) ? s.odd_plane_modulo : s.even_plane_modulo);
        end
      end
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      if (s.aw_idx == `IDX_CTL_MISC) begin
        n.plane_control_misc = merge(s.plane_control_misc, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_CTL_SCROLL) begin
        n.plane_scroll_control = merge(s.plane_scroll_control, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_CTL_PRIO) begin
        n.plane_priority_control = merge(s.plane_priority_control, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_MOD_ODD) begin
        n.odd_plane_modulo = merge(s.odd_plane_modulo, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_MOD_EVEN) begin
        n.even_plane_modulo = merge(s.even_plane_modulo, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_CLX_CONTROL) begin
        n.collision_control = merge(s.collision_control, s.w_data, s.w_strb);
      end else if (s.aw_idx == `IDX_CLX_RESULT) begin
        n.bresp = `RESP_OKAY;
      end else begin
        n.bresp = `RESP_SLVERR;
        for (int p = 0; p < NPLANES; p++) begin
          if (s.aw_idx == `IDX_PTR_BASE + 10'(p) * `IDX_PTR_STRIDE) begin
            n.ptr[p][17:15] = s.w_data[2:0];
            n.bresp = `RESP_OKAY;
          end else if (s.aw_idx == `IDX_PTR_BASE + 10'(p) * `IDX_PTR_STRIDE + `IDX_PTR_LOW_OFS) begin
            n.ptr[p][14:0] = s.w_data[15:1];
            n.bresp = `RESP_OKAY;
          end else if (s.aw_idx == `IDX_DAT_BASE + 10'(p) * `IDX_DAT_STRIDE) begin
            n.dat[p] = merge(s.dat[p], s.w_data, s.w_strb);
            n.bresp = `RESP_OKAY;
            if (p == 0) begin
              load = 1'b1;
            end
          end
        end
      end
    end
    // read side; set wins over the read clear
    // sticky result bits
    n.collision_result = s.collision_result | {1'b0, hits};
    if (s.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = `RST_WORD;
      if (s_axi_araddr_i[11:2] == `IDX_CLX_RESULT) begin
        n.rdata = s.collision_result;
        n.collision_result = {1'b0, hits};
      end else if (s_axi_araddr_i[11:2] < `IDX_CLX_RESULT || s_axi_araddr_i[11:2] >
                   `IDX_DAT_BASE + 10'(NPLANES - 1) * `IDX_DAT_STRIDE) begin
        n.rresp = `RESP_SLVERR;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    // serializer; lores takes two clocks per pixel
    // high resolution pixel rate
    step = s.plane_control_misc[`B_HIGH_RESOLUTION_SELECT] | s.half;
    n.pix.valid = 1'b0;
    case (s.ser)
      SER_IDLE: begin
        n.half = 1'b0;
      end
      SER_SHIFT: begin
        n.half = !s.half;
        if (step) begin
          for (int p = 0; p < NPLANES; p++) begin
            n.pix.planes[p] = (p < int'(active)) ? s.shreg[p][15] : 1'b0;
            n.shreg[p] = {s.shreg[p][14:0], 1'b0};
          end
          n.pix.valid = 1'b1;
          n.bits_left = s.bits_left - 5'h1;
          if (s.bits_left == 5'h1) begin
            n.ser = SER_IDLE;
          end
        end
      end
      default: begin
        n.ser = SER_IDLE;
      end
    endcase
    if (load) begin
      // plane one write starts the word
      n.shreg = n.dat;
      n.bits_left = `WORD_PIXELS;
      n.half = 1'b0;
      n.ser = SER_SHIFT;
    end
    n.fetch_addr = s.ptr[(fetch_plane_i < 3'(NPLANES)) ? fetch_plane_i : 3'h0];
    // pad inputs pass two flops before use
    n.hs_meta = hsync_pad_i;
    n.vs_meta = vsync_pad_i;
    n.hs_sync = s.hs_meta;
    n.vs_sync = s.vs_meta;
    n.hs_out = hsync_gen_i;
    n.vs_out = vsync_gen_i;
    n.sync_oe = !s.plane_control_misc[`B_EXT_SYNC];
    n.background_output_pin = (s.plane_control_misc[`B_GENLOCK] && vblank_i) ? genlock_audio_i : background_i;
    n.disp.high_resolution_select = s.plane_control_misc[`B_HIGH_RESOLUTION_SELECT];
    n.disp.plane_count = active;
    n.disp.hold_modify = s.plane_control_misc[`B_HOLD_MODIFY];
    n.disp.dual_pf = s.plane_control_misc[`B_DUAL_PF];
    n.disp.composite = s.plane_control_misc[`B_COMPOSITE];
    n.disp.genlock = s.plane_control_misc[`B_GENLOCK];
    n.disp.light_pen = s.plane_control_misc[`B_LIGHT_PEN];
    n.disp.interleave = s.plane_control_misc[`B_INTERLEAVE];
    n.disp.ext_sync = s.plane_control_misc[`B_EXT_SYNC];
    n.disp.pf2_front = s.plane_priority_control[`B_PF2_FRONT];
    n.disp.pf2_sprite_pri = s.plane_priority_control[`B_PF2_PRI_HI:`B_PF2_PRI_LO];
    n.disp.pf1_sprite_pri = s.plane_priority_control[`B_PF1_PRI_HI:`B_PF1_PRI_LO];
    n.disp.pf2_scroll = s.plane_scroll_control[`B_PF2_SCR_HI:`B_PF2_SCR_LO];
    n.disp.pf1_scroll = s.plane_scroll_control[`B_PF1_SCR_HI:`B_PF1_SCR_LO];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.ser <= SER_IDLE;
      s.sync_oe <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = {16'h0000, s.rdata};
  assign s_axi_rresp_o = s.rresp;
  assign fetch_addr_o = s.fetch_addr;
  assign hsync_pad_o = s.hs_out;
  assign vsync_pad_o = s.vs_out;
  assign sync_pad_oe_o = s.sync_oe;
  assign hsync_ext_o = s.hs_sync;
  assign vsync_ext_o = s.vs_sync;
  assign background_output_pin_o = s.background_output_pin;
  assign pixel_o = s.pix;
  assign disp_ctl_o = s.disp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_odd_mod_add: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (line_end_i && !fetch_i && active != 3'h0 && !(s.aw_got && s.w_got && !s.bvalid))
    |=> s.ptr[0] == add_mod($past(s.ptr[0]), $past(s.odd_plane_modulo)))
    else $error("odd plane pointer missed modulo");
  a_even_mod_add: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (line_end_i && !fetch_i && active > 3'h1 && !(s.aw_got && s.w_got && !s.bvalid))
    |=> s.ptr[1] == add_mod($past(s.ptr[1]), $past(s.even_plane_modulo)))
    else $error("even plane pointer missed modulo");
  a_ser_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    load |=> s.ser == SER_SHIFT && s.bits_left == `WORD_PIXELS)
    else $error("plane one load did not start serializer");
  a_msb_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s.ser == SER_SHIFT && step && !load && active != 3'h0) |=> pixel_o.valid && pixel_o.planes[0] == $past(s.shreg[0][15]))
    else $error("pixel is not the word msb");
  a_clx_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_axi_arvalid_i && s.arready && s_axi_araddr_i[11:2] == `IDX_CLX_RESULT)
    |=> s.collision_result == {1'b0, $past(hits)} && s_axi_rdata_o[15:0] == $past(s.collision_result))
    else $error("collision read did not clear");
  a_clx_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(s_axi_arvalid_i && s.arready) |=> (s.collision_result & $past(s.collision_result)) == $past(s.collision_result))
    else $error("collision bit lost without read");
  a_no_block: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s.collision_control[`B_PLANE_MATCH_INCLUDE_HI:`B_PLANE_MATCH_INCLUDE_LO] == 6'h00 && s.pix.valid) |-> hits[0])
    else $error("disabled planes blocked collision");
  a_bit15_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s.collision_result[15] == 1'b0)
    else $error("unused collision bit set");
  a_sync_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s.plane_control_misc[`B_EXT_SYNC] |=> !sync_pad_oe_o)
    else $error("sync pads driven under external sync");
  a_pf_front: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 disp_ctl_o.pf2_front == $past(s.plane_priority_control[`B_PF2_FRONT]))
    else $error("playfield order not followed");

endmodule
`default_nettype wire

// >>> playfield_consts.svh
`ifndef PLAYFIELD_CONSTS_SVH
`define PLAYFIELD_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_CLX_RESULT 10'h00e
`define IDX_CLX_CONTROL 10'h098
`define IDX_PTR_BASE 10'h0e0
`define IDX_PTR_STRIDE 10'h004
`define IDX_PTR_LOW_OFS 10'h002
`define IDX_CTL_MISC 10'h100
`define IDX_CTL_SCROLL 10'h102
`define IDX_CTL_PRIO 10'h104
`define IDX_MOD_ODD 10'h108
`define IDX_MOD_EVEN 10'h10a
`define IDX_DAT_BASE 10'h110
`define IDX_DAT_STRIDE 10'h002
// ----------------------------------------
// field positions
// ----------------------------------------
`define B_HIGH_RESOLUTION_SELECT 15
`define B_COUNT_HI 14
`define B_COUNT_LO 12
`define B_HOLD_MODIFY 11
`define B_DUAL_PF 10
`define B_COMPOSITE 9
`define B_GENLOCK 8
`define B_LIGHT_PEN 3
`define B_INTERLEAVE 2
`define B_EXT_SYNC 1
`define B_PF2_FRONT 6
`define B_PF2_PRI_HI 5
`define B_PF2_PRI_LO 3
`define B_PF1_PRI_HI 2
`define B_PF1_PRI_LO 0
`define B_PF2_SCR_HI 7
`define B_PF2_SCR_LO 4
`define B_PF1_SCR_HI 3
`define B_PF1_SCR_LO 0
`define B_ODD_SPRITE_INCLUDE_HI 15
`define B_ODD_SPRITE_INCLUDE_LO 12
`define B_PLANE_MATCH_INCLUDE_HI 11
`define B_PLANE_MATCH_INCLUDE_LO 6
`define B_PLANE_MATCH_VALUE_HI 5
`define B_PLANE_MATCH_VALUE_LO 0
// ----------------------------------------
// values and counts
// ----------------------------------------
`define RST_WORD 16'h0000
`define RST_PTR 18'h00000
`define PTR_STEP 18'h00001
`define MAX_PLANES 3'h6
`define WORD_PIXELS 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> playfield_pkg.sv
package playfield_pkg;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    logic high_resolution_select;
    logic [2:0] plane_count;
    logic hold_modify;
    logic dual_pf;
    logic composite;
    logic genlock;
    logic light_pen;
    logic interleave;
    logic ext_sync;
    logic pf2_front;
    logic [2:0] pf2_sprite_pri;
    logic [2:0] pf1_sprite_pri;
    logic [3:0] pf2_scroll;
    logic [3:0] pf1_scroll;
  } disp_ctl_t;

  typedef struct packed {
    logic valid;
    logic [5:0] planes;
  } pixel_t;
endpackage

// >>> dma_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// plane fetch channel on the far side
// ----------------------------------------
module dma_model (
  // clock
  input wire logic core_clk_i,
  // fetch strobe and payload
  output logic fetch_o,
  output logic [2:0] fetch_plane_o,
  output logic [15:0] fetch_data_o
);
  initial begin
    fetch_o = 1'b0;
    fetch_plane_o = 3'h0;
    fetch_data_o = 16'h0000;
  end

  // one word per plane, plane one last
  task automatic load(input logic [2:0] p, input logic [15:0] d);
    @(posedge core_clk_i);
    fetch_o <= 1'b1;
    fetch_plane_o <= p;
    fetch_data_o <= d;
    @(posedge core_clk_i);
    fetch_o <= 1'b0;
    // released bus must not look like live data
    fetch_data_o <= ~d;
  endtask

  task automatic select(input logic [2:0] p);
    @(posedge core_clk_i);
    fetch_plane_o <= p;
  endtask
endmodule

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb import playfield_pkg::*;;
  logic core_clk_i = 1'b0;
  logic rst_i, awv, awr, wv, wr_o, bv, br, arv, arr, rv, rr, fetch, line_end, vblank, hgen, hpad;
  logic hpad_o, vpad_o, oe, hext, vext, bg, bg_o, genlock_sound_enable;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp, r;
  logic [2:0] fplane;
  logic [15:0] fdata;
  logic [17:0] faddr;
  logic [7:0] sprite_pix;
  logic [31:0] d;
  pixel_t pixel;
  disp_ctl_t ctl;
  int bad_count = 0;
  int samples_checked = 0;
  logic [15:0] cx_ctl [3] = '{16'h0000, 16'h8000, 16'h00c3};
  logic [7:0] cx_spr [3] = '{8'h05, 8'h82, 8'h01};
  logic [15:0] cx_exp [3] = '{16'h0267, 16'h0111, 16'h0002};

  always #10 core_clk_i = ~core_clk_i;

  bitplane_playfield dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_o), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h3), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .fetch_i(fetch), .fetch_plane_i(fplane), .fetch_data_i(fdata),
    .fetch_addr_o(faddr), .line_end_i(line_end), .vblank_i(vblank), .hsync_gen_i(hgen),
    .vsync_gen_i(hgen), .sprite_pix_i(sprite_pix), .background_i(bg), .genlock_audio_i(genlock_sound_enable),
    .hsync_pad_i(hpad), .vsync_pad_i(hpad), .hsync_pad_o(hpad_o), .vsync_pad_o(vpad_o),
    .sync_pad_oe_o(oe), .hsync_ext_o(hext), .vsync_ext_o(vext), .background_output_pin_o(bg_o),
    .pixel_o(pixel), .disp_ctl_o(ctl));

  dma_model dma (.core_clk_i(core_clk_i), .fetch_o(fetch), .fetch_plane_o(fplane), .fetch_data_o(fdata));

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // both channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er);
    logic ra, rw, done;
    done = 1'b0;
    @(posedge core_clk_i);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {16'h0000, v};
    br <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(negedge core_clk_i);
      ra = awr;
      rw = wr_o;
      done = (bv === 1'b1);
      r = bresp;
      @(posedge core_clk_i);
      if (ra === 1'b1) awv <= 1'b0;
      if (rw === 1'b1) wv <= 1'b0;
      if (done) br <= 1'b0;
    end
    chk(done && r === er, "write response");
  endtask

  task automatic rd(input logic [11:0] a);
    logic ra, done;
    done = 1'b0;
    @(posedge core_clk_i);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(negedge core_clk_i);
      ra = arr;
      done = (rv === 1'b1);
      d = rdat;
      r = rresp;
      @(posedge core_clk_i);
      if (ra === 1'b1) arv <= 1'b0;
      if (done) rr <= 1'b0;
    end
    chk(done, "read timeout");
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    rd(a);
    chk(d === {16'h0000, e} && r === er, "read value");
  endtask

  task automatic ptr_chk(input logic [2:0] p, input logic [17:0] e);
    dma.select(p);
    repeat (2) @(negedge core_clk_i);
    chk(faddr === e, "plane pointer");
  endtask

  // sixteen pixels, msb first, span = cycles from first to last pixel
  task automatic collect(input logic [15:0] w0, input logic [15:0] w1, input int span);
    int n, first, last;
    n = 0;
    first = -1;
    last = 0;
    for (int c = 0; c < 80; c++) begin
      @(negedge core_clk_i);
      if (pixel.valid === 1'b1) begin
        if (first < 0) first = c;
        last = c;
        if (n < 16) chk(pixel.planes === {4'h0, w1[15-n], w0[15-n]}, "pixel bits");
        n++;
      end
    end
    chk(n == 16 && last - first == span, "pixel count or spacing");
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("mismatch at %0t: watchdog", $time);
    end_of_test();
  end

  initial begin
    {rst_i, awv, wv, br, arv, rr, line_end, vblank, hgen, hpad, bg, genlock_sound_enable} = 12'h800;
    {awa, ara, wd, sprite_pix} = '0;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    hgen <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(ctl === '0, "control reset");
    chk(oe === 1'b1 && hpad_o === 1'b1 && vpad_o === 1'b1, "sync pads driven");
    rd_chk(12'h038, 16'h0000, 2'h0);
    rd_chk(12'h400, 16'h0000, 2'h0);
    rd_chk(12'h000, 16'h0000, 2'h2);
    wr(12'h000, 16'hffff, 2'h2);
    $display("test reset done");

    wr(12'h400, 16'hbf0e, 2'h0);
    wr(12'h408, 16'h00a5, 2'h0);
    wr(12'h410, 16'h0055, 2'h0);
    hpad <= 1'b1;
    vblank <= 1'b1;
    genlock_sound_enable <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk({ctl.high_resolution_select, ctl.plane_count} === 4'hb, "resolution and count");
    chk({ctl.hold_modify, ctl.dual_pf, ctl.composite, ctl.genlock} === 4'hf, "colour modes");
    chk({ctl.light_pen, ctl.interleave, ctl.ext_sync} === 3'h7, "misc bits");
    chk({ctl.pf2_scroll, ctl.pf1_scroll} === 8'ha5, "scroll codes");
    chk({ctl.pf2_front, ctl.pf2_sprite_pri, ctl.pf1_sprite_pri} === 7'h55, "priority");
    chk(oe === 1'b0 && hext === 1'b1 && vext === 1'b1, "sync pads as inputs");
    chk(bg_o === 1'b1, "audio on background pin");
    vblank <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk(bg_o === 1'b0, "background outside vblank");
    $display("test control done");

    wr(12'h400, 16'h2000, 2'h0);
    wr(12'h380, 16'h0005, 2'h0);
    wr(12'h388, 16'h1234, 2'h0);
    wr(12'h390, 16'h0000, 2'h0);
    wr(12'h398, 16'h0100, 2'h0);
    wr(12'h420, 16'h0010, 2'h0);
    wr(12'h428, 16'hfffc, 2'h0);
    ptr_chk(3'h0, 18'h2891a);
    @(posedge core_clk_i);
    line_end <= 1'b1;
    @(posedge core_clk_i);
    line_end <= 1'b0;
    ptr_chk(3'h0, 18'h28922);
    ptr_chk(3'h1, 18'h0007e);
    $display("test pointers done");

    wr(12'h400, 16'ha000, 2'h0);
    wr(12'h448, 16'h5a0f, 2'h0);
    dma.load(3'h0, 16'h8c31);
    collect(16'h8c31, 16'h5a0f, 15);
    wr(12'h400, 16'h1000, 2'h0);
    dma.load(3'h1, 16'hffff);
    dma.load(3'h0, 16'h3c96);
    collect(16'h3c96, 16'h0000, 30);
    $display("test serializer done");

    wr(12'h400, 16'h2000, 2'h0);
    for (int i = 0; i < 3; i++) begin
      wr(12'h260, cx_ctl[i], 2'h0);
      rd(12'h038);
      sprite_pix <= cx_spr[i];
      dma.load(3'h1, 16'h0000);
      dma.load(3'h0, 16'hffff);
      repeat (36) @(posedge core_clk_i);
      sprite_pix <= 8'h00;
      rd_chk(12'h038, cx_exp[i], 2'h0);
      rd_chk(12'h038, 16'h0000, 2'h0);
    end
    $display("test collisions done");
    end_of_test();
  end
endmodule

`default_nettype wire
